// *** dv/fwie_phy_model.sv ***
`timescale 1ns/1ns
// ------------------------------
// PHY side of the link
// ------------------------------
module fwie_phy_model
(
	input  wire logic       clk,
	input  wire logic       link_run,
	input  wire logic [6:0] phy_req,
	output logic            link_clk,
	output logic            cycle_count_lsb,
	output logic            cycle_seconds_bit6,
	output wire logic       cycle_start_seen,
	output wire logic       subaction_gap,
	output wire logic       arb_reset_gap,
	output wire logic       phy_status_request,
	output wire logic       phy_link_reinit
);
	logic [4:0] hold0_ff, hold1_ff, hold2_ff, hold3_ff;

	// Link clock stands still while link_run is low
	initial
	begin
		link_clk = 1'b0;
		#13;
		forever
		begin
			#40;
			if (link_run)
				link_clk = ~link_clk;
		end
	end

	initial
	begin
		cycle_count_lsb = 1'b0;
		cycle_seconds_bit6 = 1'b0;
		{hold0_ff, hold1_ff, hold2_ff, hold3_ff} = '0;
	end

	always @(posedge clk)
	begin
		if (phy_req[0])
			cycle_count_lsb <= ~cycle_count_lsb;
		if (phy_req[1])
			cycle_seconds_bit6 <= ~cycle_seconds_bit6;
		hold0_ff <= phy_req[6:2];
		hold1_ff <= hold0_ff;
		hold2_ff <= hold1_ff;
		hold3_ff <= hold2_ff;
	end

	// Each event stays high four clocks so the block's synchroniser catches it
	assign {phy_link_reinit, phy_status_request, arb_reset_gap, subaction_gap,
		cycle_start_seen} = hold0_ff | hold1_ff | hold2_ff | hold3_ff;
endmodule

// *** dv/fwie_top_tb.sv ***
`timescale 1ns/1ns
`include "fwie_defines.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module fwie_top_tb;
	// ------------------------------
	// Signals
	// ------------------------------
	logic        clk, reset_n;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb, dma_cmd_irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic        link_clk, cycle_count_lsb, cycle_seconds_bit6, cycle_start_seen;
	logic        subaction_gap, arb_reset_gap, phy_status_request, phy_link_reinit;
	logic [8:0]  sc_src;
	logic        link_reg_access, event_pending, link_clk_lost, link_run;
	logic [31:0] iso_rx_event, iso_rx_mask, iso_tx_event, iso_tx_mask;
	logic [22:0] event_mask, event_flags;
	logic [6:0]  phy_req;
	int          miscompares, cmp_count;
	localparam logic [22:0] SC_EXP [0:8] = '{23'h000001, 23'h000002, 23'h000004,
		23'h000008, 23'h000010, 23'h000020, 23'h000100, 23'h000200, 23'h018000};

	fwie_top #(.LINK_LOSS_CYC(8'h14)) dut
	(
		.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_clk, .cycle_count_lsb,
		.cycle_seconds_bit6, .cycle_start_seen, .subaction_gap, .arb_reset_gap,
		.phy_status_request, .phy_link_reinit,
		.node_id_stream_done(sc_src[8]), .lock_reply_unacked(sc_src[7]),
		.posted_store_fault(sc_src[6]), .response_packet_arrived(sc_src[5]),
		.request_packet_arrived(sc_src[4]), .dma_cmd_done(sc_src[3:0]), .dma_cmd_irq,
		.link_reg_access, .iso_rx_event, .iso_rx_mask, .iso_tx_event, .iso_tx_mask,
		.event_mask, .event_flags, .event_pending, .link_clk_lost
	);

	fwie_phy_model phy_side
	(
		.clk, .link_run, .phy_req, .link_clk, .cycle_count_lsb, .cycle_seconds_bit6,
		.cycle_start_seen, .subaction_gap, .arb_reset_gap, .phy_status_request,
		.phy_link_reinit
	);

	always #4 clk = ~clk;

	// ------------------------------
	// Access tasks
	// ------------------------------
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		`CHK(s_axi_bresp, er)
		s_axi_bready <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		`CHK(s_axi_rdata, ed)
		`CHK(s_axi_rresp, er)
		s_axi_rready <= 1'b0;
	endtask

	task automatic settle;
		repeat (8) @(posedge clk);
	endtask

	task automatic chkf(input logic [22:0] e);
		settle;
		`CHK(event_flags, e)
	endtask

	task automatic clr;
		axw(`FWIE_OFS_EVENT_CLR, 32'hffffffff, 4'hf, `FWIE_RESP_OKAY);
	endtask

	task automatic sc(input logic [8:0] v);
		@(posedge clk);
		sc_src <= v;
		@(posedge clk);
		sc_src <= '0;
		settle;
	endtask

	task automatic phy(input int b);
		@(posedge clk);
		phy_req <= 7'(1 << b);
		@(posedge clk);
		phy_req <= '0;
		settle;
	endtask

	task automatic cyc;
		phy(2);
		phy(0);
		clr;
	endtask

	task automatic acc;
		@(posedge clk);
		link_reg_access <= 1'b1;
		@(posedge clk);
		link_reg_access <= 1'b0;
	endtask

	task automatic finish_test;
		if (miscompares == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ------------------------------
	// Tests
	// ------------------------------
	initial
	begin
		repeat (10000) @(posedge clk);
		miscompares++;
		finish_test;
	end

	initial
	begin
		clk = 1'b0;
		reset_n = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		sc_src = '0;
		dma_cmd_irq = 4'h0;
		link_reg_access = 1'b0;
		{iso_rx_event, iso_rx_mask, iso_tx_event, iso_tx_mask} = '0;
		event_mask = 23'h7fffff;
		link_run = 1'b1;
		phy_req = '0;
		miscompares = 0;
		cmp_count = 0;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		axr(`FWIE_OFS_EVENT_SET, 32'h0, `FWIE_RESP_OKAY);
		axw(`FWIE_OFS_EVENT_SET, 32'hffffffff, 4'hf, `FWIE_RESP_OKAY);
		axr(`FWIE_OFS_EVENT_SET, {9'h0, `FWIE_LATCH_MASK}, `FWIE_RESP_OKAY);
		axr(`FWIE_OFS_EVENT_CLR, {9'h0, `FWIE_LATCH_MASK}, `FWIE_RESP_OKAY);
		axw(8'h88, 32'hffffffff, 4'hf, `FWIE_RESP_DECERR);
		axr(8'h88, 32'h0, `FWIE_RESP_DECERR);
		event_mask <= 23'h00000f;
		axr(`FWIE_OFS_EVENT_SET, 32'h0000000f, `FWIE_RESP_OKAY);
		settle;
		`CHK(event_pending, 1'b1)
		axw(`FWIE_OFS_EVENT_CLR, 32'h0000000c, 4'hf, `FWIE_RESP_OKAY);
		axr(`FWIE_OFS_EVENT_SET, 32'h00000003, `FWIE_RESP_OKAY);
		event_mask <= 23'h0;
		settle;
		`CHK(event_pending, 1'b0)
		event_mask <= 23'h7fffff;
		clr;
		axw(`FWIE_OFS_EVENT_SET, 32'hffffffff, 4'h1, `FWIE_RESP_OKAY);
		chkf(23'h00003f);
		clr;
		sc(9'h00f);
		`CHK(event_flags, 23'h0)
		dma_cmd_irq <= 4'hf;
		for (int i = 0; i < 9; i++)
		begin
			clr;
			sc(9'(1 << i));
			`CHK(event_flags, SC_EXP[i])
		end
		phy(6);
		`CHK(event_flags, 23'h028000)
		axw(`FWIE_OFS_EVENT_CLR, 32'h00020000, 4'hf, `FWIE_RESP_OKAY);
		chkf(23'h008000);
		clr;
		phy(1);
		chkf(23'h200000);
		phy(5);
		chkf(23'h280000);
		clr;
		phy(0);
		`CHK(event_flags[20], 1'b1)
		cyc;
		phy(2);
		phy(0);
		chkf(23'h100000);
		clr;
		phy(0);
		chkf(23'h500000);
		cyc;
		phy(4);
		chkf(23'h400000);
		cyc;
		phy(3);
		phy(2);
		chkf(23'h0);
		cyc;
		phy(3);
		phy(3);
		chkf(23'h400000);
		cyc;
		@(posedge clk);
		phy_req <= 7'h08;
		@(posedge clk);
		phy_req <= 7'h10;
		@(posedge clk);
		phy_req <= 7'h00;
		chkf(23'h400000);
		clr;
		iso_rx_event <= 32'h80000000;
		iso_rx_mask <= 32'h80000001;
		iso_tx_event <= 32'h00000001;
		chkf(23'h000080);
		iso_rx_mask <= 32'h00000001;
		iso_tx_mask <= 32'h00000001;
		chkf(23'h000040);
		axr(`FWIE_OFS_EVENT_SET, 32'h00000040, `FWIE_RESP_OKAY);
		iso_tx_event <= 32'h0;
		chkf(23'h0);
		acc;
		chkf(23'h0);
		link_run <= 1'b0;
		repeat (40) @(posedge clk);
		`CHK(link_clk_lost, 1'b1)
		acc;
		chkf(23'h040000);
		link_run <= 1'b1;
		repeat (40) @(posedge clk);
		`CHK(link_clk_lost, 1'b0)
		reset_n <= 1'b0;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		chkf(23'h0);
		axr(`FWIE_OFS_EVENT_SET, 32'h0, `FWIE_RESP_OKAY);
		finish_test;
	end
endmodule

// *** rtl/fwie_defines.svh ***
`ifndef FWIE_DEFINES_SVH
`define FWIE_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets and bus answers
// ----------------------------------------------------------------
`define FWIE_OFS_EVENT_SET   8'h80
`define FWIE_OFS_EVENT_CLR   8'h84
`define FWIE_RESP_OKAY       2'b00
`define FWIE_RESP_DECERR     2'b11

// ----------------------------------------------------------------
// Event bit positions
// ----------------------------------------------------------------
`define FWIE_BIT_LOST_CYCLE  22
`define FWIE_BIT_SIXTY_FOUR  21
`define FWIE_BIT_NEW_CYCLE   20
`define FWIE_BIT_PHY_STATUS  19
`define FWIE_BIT_REG_FAULT   18
`define FWIE_BIT_REINIT      17
`define FWIE_BIT_ID_DONE     16
`define FWIE_BIT_ID_STICKY   15
`define FWIE_BIT_LOCK_ERR    9
`define FWIE_BIT_POST_ERR    8
`define FWIE_BIT_ISO_RX      7
`define FWIE_BIT_ISO_TX      6
`define FWIE_BIT_RSP_PKT     5
`define FWIE_BIT_REQ_PKT     4
`define FWIE_BIT_DMA_BASE    0

// ----------------------------------------------------------------
// Field masks and reset values
// ----------------------------------------------------------------
`define FWIE_LATCH_MASK      23'h7f833f
`define FWIE_RESERVED_MASK   23'h007c00
`define FWIE_FLAGS_RESET     23'h000000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FWIE_CLK_MHZ         125
`define FWIE_LINK_LOSS_NS    400
`define FWIE_LINK_LOSS_CYC   ((`FWIE_LINK_LOSS_NS * `FWIE_CLK_MHZ + 999) / 1000)

`endif

// *** rtl/fwie_pkg.sv ***
package fwie_pkg;

	typedef logic [22:0] fwie_flags_t;

	typedef enum logic [1:0]
	{
		FWIE_CL_IDLE       = 2'b00,
		FWIE_CL_WAIT_START = 2'b01,
		FWIE_CL_GAP_SEEN   = 2'b10,
		FWIE_CL_PREDICTED  = 2'b11
	} fwie_cycle_state_e;

	typedef enum logic [0:0]
	{
		FWIE_WR_ACCEPT = 1'b0,
		FWIE_WR_RESP   = 1'b1
	} fwie_wr_state_e;

endpackage

// *** rtl/fwie_top.sv ***
// What this block does
// - Flag lost cycle: no start between cycles
// - Predict lost cycle from gaps early
// - Flag seconds counter bit six change
// - Flag new cycle on count LSB toggle
// - Flag PHY status transfer interrupt request
// - Flag register access without link clock
// - Flag PHY entering link reinitialisation
// - Flag node ID stream reception done
// - Reinit clears stream done same cycle
// - Sticky done set with done, survives reinit
// - Reserved bits fourteen to ten read zero
// - Flag unacknowledged lock reply
// - Flag host fault on posted store
// - Bit seven: live iso receive summary
// - Bit six: live iso transmit summary
// - Flag response packet arrived, descriptor updated
// - Flag request packet arrived, descriptor updated
// - Bit three on receive response completion
// - Bit two on receive request completion
// - Bit one on response send done
// - Bit zero on request send done
// - Set on source edge or set write
// - Clear by clear view write; reinit also clears stream done
// - Reads return flags ANDed with mask
// - Set view 80h, clear view 84h
`timescale 1ns/1ns
`include "fwie_defines.svh"

module fwie_top
#(
	parameter int          ADDR_W        = 8,
	parameter int          ISO_CTX       = 32,
	parameter logic [7:0]  LINK_LOSS_CYC = 8'(`FWIE_LINK_LOSS_CYC)
)
(
	input  wire logic               clk,
	input  wire logic               reset_n,
	input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output wire logic               s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output wire logic               s_axi_wready,
	output wire logic [1:0]         s_axi_bresp,
	output wire logic               s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [ADDR_W-1:0]  s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output wire logic               s_axi_arready,
	output wire logic [31:0]        s_axi_rdata,
	output wire logic [1:0]         s_axi_rresp,
	output wire logic               s_axi_rvalid,
	input  wire logic               s_axi_rready,
	input  wire logic               link_clk,
	input  wire logic               cycle_count_lsb,
	input  wire logic               cycle_seconds_bit6,
	input  wire logic               cycle_start_seen,
	input  wire logic               subaction_gap,
	input  wire logic               arb_reset_gap,
	input  wire logic               phy_status_request,
	input  wire logic               phy_link_reinit,
	input  wire logic               node_id_stream_done,
	input  wire logic               lock_reply_unacked,
	input  wire logic               posted_store_fault,
	input  wire logic               response_packet_arrived,
	input  wire logic               request_packet_arrived,
	input  wire logic [3:0]         dma_cmd_done,
	input  wire logic [3:0]         dma_cmd_irq,
	input  wire logic               link_reg_access,
	input  wire logic [ISO_CTX-1:0] iso_rx_event,
	input  wire logic [ISO_CTX-1:0] iso_rx_mask,
	input  wire logic [ISO_CTX-1:0] iso_tx_event,
	input  wire logic [ISO_CTX-1:0] iso_tx_mask,
	input  wire logic [22:0]        event_mask,
	output wire logic [22:0]        event_flags,
	output wire logic               event_pending,
	output wire logic               link_clk_lost
);

	// ----------------------------------------------------------------
	// Link side synchronisers
	// ----------------------------------------------------------------
	localparam int LNK_N = 8;

	logic [LNK_N-1:0] lnk_s1_ff;
	logic [LNK_N-1:0] lnk_s2_ff;
	logic [LNK_N-1:0] lnk_s3_ff;
	logic [2:0]       lnk_vld_ff;
	wire  [LNK_N-1:0] lnk_raw;
	wire  [LNK_N-1:0] lnk_rise;
	wire  [LNK_N-1:0] lnk_change;

	assign lnk_raw = {phy_link_reinit, phy_status_request, arb_reset_gap, subaction_gap,
		cycle_start_seen, cycle_seconds_bit6, cycle_count_lsb, link_clk};
	// Hold off edge detection until both stages carry pin values
	assign lnk_rise   = lnk_s2_ff & ~lnk_s3_ff & {LNK_N{lnk_vld_ff[2]}};
	assign lnk_change = (lnk_s2_ff ^ lnk_s3_ff) & {LNK_N{lnk_vld_ff[2]}};

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			lnk_s1_ff <= '0;
			lnk_s2_ff <= '0;
			lnk_s3_ff <= '0;
			lnk_vld_ff <= 3'h0;
		end
		else
		begin
			lnk_s1_ff <= lnk_raw;
			lnk_s2_ff <= lnk_s1_ff;
			lnk_s3_ff <= lnk_s2_ff;
			lnk_vld_ff <= {lnk_vld_ff[1:0], 1'b1};
		end
	end

	wire clk_edge       = lnk_change[0];
	wire new_cycle_evt  = lnk_change[1];
	wire sec_change_evt = lnk_change[2];
	wire cyc_start_evt  = lnk_rise[3];
	wire sub_gap_evt    = lnk_rise[4];
	wire arb_gap_evt    = lnk_rise[5];
	wire phy_req_evt    = lnk_rise[6];
	wire reinit_evt     = lnk_rise[7];

	// ----------------------------------------------------------------
	// Link clock watchdog
	// ----------------------------------------------------------------
	logic [7:0] loss_cnt_ff;
	logic       link_lost_ff;
	wire        loss_hit = (loss_cnt_ff >= LINK_LOSS_CYC);
	wire  [7:0] nxt_loss_cnt = clk_edge ? 8'h00 : (loss_hit ? loss_cnt_ff : loss_cnt_ff + 8'h01);

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			loss_cnt_ff  <= 8'h00;
			link_lost_ff <= 1'b0;
		end
		else
		begin
			loss_cnt_ff  <= nxt_loss_cnt;
			link_lost_ff <= (nxt_loss_cnt >= LINK_LOSS_CYC);
		end
	end

	// ----------------------------------------------------------------
	// Same clock source edges
	// ----------------------------------------------------------------
	logic [12:0] src_prev_ff;
	wire  [12:0] src_now = {1'b0, link_reg_access, dma_cmd_done & dma_cmd_irq, request_packet_arrived,
		response_packet_arrived, posted_store_fault, lock_reply_unacked,
		node_id_stream_done, 2'b00};
	wire  [12:0] src_rise = src_now & ~src_prev_ff;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			src_prev_ff <= '0;
		else
			src_prev_ff <= src_now;
	end

	wire       id_done_evt  = src_rise[2];
	wire       lock_evt     = src_rise[3];
	wire       post_evt     = src_rise[4];
	wire       rsp_pkt_evt  = src_rise[5];
	wire       req_pkt_evt  = src_rise[6];
	wire [3:0] dma_evt      = src_rise[10:7];
	wire       reg_acc_evt  = src_rise[11];
	wire       reg_fail_evt = reg_acc_evt & link_lost_ff;

	// ----------------------------------------------------------------
	// Lost cycle tracking
	// ----------------------------------------------------------------
	fwie_pkg::fwie_cycle_state_e cl_state_ff;
	fwie_pkg::fwie_cycle_state_e nxt_cl_state;
	logic                        lost_evt;

	always_comb
	begin
		nxt_cl_state = cl_state_ff;
		lost_evt     = 1'b0;
		if (new_cycle_evt)
		begin
			lost_evt     = (cl_state_ff != fwie_pkg::FWIE_CL_IDLE);
			nxt_cl_state = fwie_pkg::FWIE_CL_WAIT_START;
		end
		else if (cyc_start_evt)
			nxt_cl_state = fwie_pkg::FWIE_CL_IDLE;
		else
		begin
			case (cl_state_ff)
				fwie_pkg::FWIE_CL_WAIT_START:
				begin
					if (arb_gap_evt)
					begin
						lost_evt     = 1'b1;
						nxt_cl_state = fwie_pkg::FWIE_CL_PREDICTED;
					end
					else if (sub_gap_evt)
						nxt_cl_state = fwie_pkg::FWIE_CL_GAP_SEEN;
				end
				fwie_pkg::FWIE_CL_GAP_SEEN:
				begin
					if (arb_gap_evt || sub_gap_evt)
					begin
						lost_evt     = 1'b1;
						nxt_cl_state = fwie_pkg::FWIE_CL_PREDICTED;
					end
				end
				default:
					nxt_cl_state = cl_state_ff;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			cl_state_ff <= fwie_pkg::FWIE_CL_IDLE;
		else
			cl_state_ff <= nxt_cl_state;
	end

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	logic                    awready_ff;
	logic                    wready_ff;
	logic                    bvalid_ff;
	logic [1:0]              bresp_ff;
	logic                    arready_ff;
	logic                    rvalid_ff;
	logic [1:0]              rresp_ff;
	logic [31:0]             rdata_ff;
	logic                    aw_have_ff;
	logic                    w_have_ff;
	logic [ADDR_W-1:0]       awaddr_ff;
	logic [31:0]             wdata_ff;
	logic [3:0]              wstrb_ff;
	fwie_pkg::fwie_wr_state_e wr_state_ff;

	wire aw_hs   = s_axi_awvalid & awready_ff;
	wire w_hs    = s_axi_wvalid & wready_ff;
	wire ar_hs   = s_axi_arvalid & arready_ff;
	wire wr_fire = aw_have_ff & w_have_ff & (wr_state_ff == fwie_pkg::FWIE_WR_ACCEPT);
	wire b_done  = bvalid_ff & s_axi_bready;
	wire r_done  = rvalid_ff & s_axi_rready;

	wire nxt_aw_have = aw_hs | (aw_have_ff & ~wr_fire);
	wire nxt_w_have  = w_hs | (w_have_ff & ~wr_fire);
	wire nxt_bvalid  = wr_fire | (bvalid_ff & ~b_done);
	wire nxt_rvalid  = ar_hs | (rvalid_ff & ~r_done);

	wire [31:0] strb_bits = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
	wire        wr_is_set = (awaddr_ff == `FWIE_OFS_EVENT_SET);
	wire        wr_is_clr = (awaddr_ff == `FWIE_OFS_EVENT_CLR);
	wire        rd_hit    = (s_axi_araddr == `FWIE_OFS_EVENT_SET) ||
		(s_axi_araddr == `FWIE_OFS_EVENT_CLR);
	wire [22:0] wr_bits   = wdata_ff[22:0] & strb_bits[22:0] & `FWIE_LATCH_MASK;
	wire [22:0] sw_set    = (wr_fire && wr_is_set) ? wr_bits : 23'h000000;
	wire [22:0] sw_clr    = (wr_fire && wr_is_clr) ? wr_bits : 23'h000000;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			awready_ff  <= 1'b0;
			wready_ff   <= 1'b0;
			arready_ff  <= 1'b0;
			aw_have_ff  <= 1'b0;
			w_have_ff   <= 1'b0;
			bvalid_ff   <= 1'b0;
			rvalid_ff   <= 1'b0;
			wr_state_ff <= fwie_pkg::FWIE_WR_ACCEPT;
		end
		else
		begin
			aw_have_ff  <= nxt_aw_have;
			w_have_ff   <= nxt_w_have;
			bvalid_ff   <= nxt_bvalid;
			rvalid_ff   <= nxt_rvalid;
			awready_ff  <= ~nxt_aw_have & ~nxt_bvalid;
			wready_ff   <= ~nxt_w_have & ~nxt_bvalid;
			arready_ff  <= ~nxt_rvalid;
			wr_state_ff <= nxt_bvalid ? fwie_pkg::FWIE_WR_RESP : fwie_pkg::FWIE_WR_ACCEPT;
		end
	end

	// ----------------------------------------------------------------
	// Event flags
	// ----------------------------------------------------------------
	fwie_pkg::fwie_flags_t flags_ff;
	logic [22:0]           hw_set;
	logic [22:0]           nxt_flags;

	wire iso_rx_any = |(iso_rx_event & iso_rx_mask);
	wire iso_tx_any = |(iso_tx_event & iso_tx_mask);
	wire [22:0] live_flags = flags_ff | ({22'h000000, iso_rx_any} << `FWIE_BIT_ISO_RX) |
		({22'h000000, iso_tx_any} << `FWIE_BIT_ISO_TX);
	wire [22:0] read_word  = live_flags & event_mask & ~`FWIE_RESERVED_MASK;

	always_comb
	begin
		hw_set = 23'h000000;
		hw_set[`FWIE_BIT_LOST_CYCLE] = lost_evt;
		hw_set[`FWIE_BIT_SIXTY_FOUR] = sec_change_evt;
		hw_set[`FWIE_BIT_NEW_CYCLE]  = new_cycle_evt;
		hw_set[`FWIE_BIT_PHY_STATUS] = phy_req_evt;
		hw_set[`FWIE_BIT_REG_FAULT]  = reg_fail_evt;
		hw_set[`FWIE_BIT_REINIT]     = reinit_evt;
		hw_set[`FWIE_BIT_ID_DONE]    = id_done_evt;
		hw_set[`FWIE_BIT_ID_STICKY]  = id_done_evt;
		hw_set[`FWIE_BIT_LOCK_ERR]   = lock_evt;
		hw_set[`FWIE_BIT_POST_ERR]   = post_evt;
		hw_set[`FWIE_BIT_RSP_PKT]    = rsp_pkt_evt;
		hw_set[`FWIE_BIT_REQ_PKT]    = req_pkt_evt;
		hw_set[3:0]                  = dma_evt;
		// Hardware and software set win over a software clear in the same cycle
		nxt_flags = ((flags_ff & ~sw_clr) | hw_set | sw_set) & `FWIE_LATCH_MASK;
		if (reinit_evt)
			nxt_flags[`FWIE_BIT_ID_DONE] = 1'b0;
	end

	logic [22:0] event_flags_ff;
	logic        event_pending_ff;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			flags_ff         <= `FWIE_FLAGS_RESET;
			event_flags_ff   <= `FWIE_FLAGS_RESET;
			event_pending_ff <= 1'b0;
		end
		else
		begin
			flags_ff         <= nxt_flags;
			event_flags_ff   <= live_flags;
			event_pending_ff <= |read_word;
		end
	end

	// ----------------------------------------------------------------
	// Bus payload registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			awaddr_ff <= '0;
			wdata_ff  <= 32'h00000000;
			wstrb_ff  <= 4'h0;
			bresp_ff  <= `FWIE_RESP_OKAY;
			rresp_ff  <= `FWIE_RESP_OKAY;
			rdata_ff  <= 32'h00000000;
		end
		else
		begin
			if (aw_hs)
				awaddr_ff <= s_axi_awaddr;
			if (w_hs)
			begin
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (wr_fire)
				bresp_ff <= (wr_is_set || wr_is_clr) ? `FWIE_RESP_OKAY : `FWIE_RESP_DECERR;
			if (ar_hs)
			begin
				rresp_ff <= rd_hit ? `FWIE_RESP_OKAY : `FWIE_RESP_DECERR;
				rdata_ff <= rd_hit ? {9'h000, read_word} : 32'h00000000;
			end
		end
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = wready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rresp   = rresp_ff;
	assign s_axi_rdata   = rdata_ff;
	assign event_flags   = event_flags_ff;
	assign event_pending = event_pending_ff;
	assign link_clk_lost = link_lost_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_cycle_pending;
		cl_state_ff == fwie_pkg::FWIE_CL_WAIT_START && !new_cycle_evt && !cyc_start_evt;
	endsequence

	sequence s_write_taken;
		wr_fire;
	endsequence

	property p_lost_repeat;
		new_cycle_evt && cl_state_ff != fwie_pkg::FWIE_CL_IDLE |=> flags_ff[22];
	endproperty
	a_lost_repeat: assert property (p_lost_repeat) else $error("lost cycle missed");

	property p_lost_predict;
		s_cycle_pending ##0 (sub_gap_evt && !arb_gap_evt) ##1
			(!new_cycle_evt && !cyc_start_evt && arb_gap_evt) |=> flags_ff[22];
	endproperty
	a_lost_predict: assert property (p_lost_predict) else $error("no lost prediction");

	property p_sixty_four;
		lnk_vld_ff[2] && $changed(lnk_s2_ff[2]) |=> flags_ff[21];
	endproperty
	a_sixty_four: assert property (p_sixty_four) else $error("seconds flag missed");

	property p_new_cycle;
		lnk_vld_ff[2] && lnk_s2_ff[1] != $past(lnk_s2_ff[1]) |=> flags_ff[20];
	endproperty
	a_new_cycle: assert property (p_new_cycle) else $error("new cycle flag missed");

	property p_reg_fault;
		link_reg_access && !src_prev_ff[11] && loss_cnt_ff >= LINK_LOSS_CYC && !clk_edge
			##1 link_lost_ff |=> flags_ff[18];
	endproperty
	a_reg_fault: assert property (p_reg_fault) else $error("access fault missed");

	property p_reinit;
		reinit_evt |=> flags_ff[17] && !flags_ff[16];
	endproperty
	a_reinit: assert property (p_reinit) else $error("reinit handling wrong");

	property p_id_done;
		id_done_evt && !reinit_evt |=> flags_ff[16] && flags_ff[15];
	endproperty
	a_id_done: assert property (p_id_done) else $error("stream done flags missed");

	property p_sticky_keep;
		flags_ff[15] && !sw_clr[15] |=> flags_ff[15];
	endproperty
	a_sticky_keep: assert property (p_sticky_keep) else $error("flag lost without clear");

	property p_reserved;
		rvalid_ff |-> rdata_ff[14:10] == 5'h00 && rdata_ff[31:23] == 9'h000;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

	property p_iso_summary;
		reset_n |=> event_flags_ff[7] == $past(iso_rx_any) && event_flags_ff[6] == $past(iso_tx_any);
	endproperty
	a_iso_summary: assert property (p_iso_summary) else $error("iso summary wrong");

	property p_read_masked;
		ar_hs && rd_hit |=> rvalid_ff && rdata_ff[22:0] == $past(read_word);
	endproperty
	a_read_masked: assert property (p_read_masked) else $error("read not masked");

	property p_write_resp;
		s_write_taken |=> bvalid_ff && ((bresp_ff == `FWIE_RESP_OKAY) == $past(wr_is_set || wr_is_clr));
	endproperty
	a_write_resp: assert property (p_write_resp) else $error("write answer wrong");

endmodule
